/* sbs_burst_seq.sv */
// Burst address generator: low two address bits for one step of a burst.
// Assumes start and step count come from registers of the same clock.
`timescale 1ns/100ps
`default_nettype none
module sbs_burst_seq
  import sbs_pkg::*;
(
  input  wire logic [1:0] start_i,   // first low address of the burst
  input  wire logic [1:0] step_i,    // steps taken so far
  input  wire logic       linear_i,  // high: linear order
  output logic      [1:0] low_o      // low address bits for this step
);
  // 2-bit arithmetic wraps inside the aligned group of four
  always_comb begin
    if (linear_i) begin
      low_o = 2'(start_i + step_i);
    end else begin
      low_o = start_i ^ step_i;
    end
  end
endmodule // sbs_burst_seq
`default_nettype wire

/* sbs_ctrl_model.sv */
// Controller-side model of the burst SRAM pin bus: drives every synchronous
// pin one cycle per call and resolves the four shared data lanes.
// Assumes the bench calls cyc() once a clock and nothing else drives pins.
`timescale 1ns/100ps
`default_nettype none
module sbs_ctrl_model
  import sbs_pkg::*;
(
  input  wire logic        clk_i,      // block clock
  input  wire logic [35:0] dev_q_i,    // device read data, four lanes
  input  wire logic [3:0]  dev_oe_n_i, // device lane drive, low drives
  output logic      [16:0] addr_o,     // full word address
  output logic             pstb_n_o,   // processor strobe
  output logic             cstb_n_o,   // controller strobe
  output logic             adv_n_o,    // burst advance
  output logic             cen_n_o,    // primary select
  output logic             sel_n_o,    // low-active extra select
  output logic             sel_o,      // high-active extra select
  output logic             gate_n_o,   // byte-write gate
  output logic             all_n_o,    // all-lanes write
  output logic      [3:0]  wen_n_o,    // lane write enables
  output logic             order_n_o,  // burst order, low linear
  output logic             oe_n_o,     // output enable
  output logic      [35:0] bus_o       // resolved data lanes
);
  logic [35:0] wd_r;
  logic        drv_r;
  logic [35:0] last_r;

  initial begin
    {pstb_n_o, cstb_n_o, adv_n_o, cen_n_o} = 4'hF;
    {sel_o, sel_n_o, gate_n_o, all_n_o, wen_n_o} = 8'hBF;
    addr_o = 17'h00000;
    wd_r = 36'h000000000;
    drv_r = 1'h0;
    last_r = 36'h000000000;
    order_n_o = 1'h0;
    oe_n_o = 1'h0;
  end

  // a released lane has no pull, so it shows the inverse of its last level
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign bus_o[g*9+:9] = !dev_oe_n_i[g] ? dev_q_i[g*9+:9] :
                           drv_r ? wd_r[g*9+:9] : ~last_r[g*9+:9];
  end

  always @(posedge clk_i) last_r <= bus_o;

  // pins change just after the edge and hold until the next one
  task automatic cyc(input logic [3:0] strb, input logic [16:0] a,
                     input logic [7:0] ctl, input logic [35:0] d);
    @(posedge clk_i);
    {pstb_n_o, cstb_n_o, adv_n_o, cen_n_o} <= strb;
    addr_o <= a;
    {sel_o, sel_n_o, gate_n_o, all_n_o, wen_n_o} <= ctl;
    wd_r <= d;
    drv_r <= !ctl[4] || (!ctl[5] && ctl[3:0] != 4'hF);
  endtask

  // static pins; costs one cycle, so call it only with no read in flight
  task automatic set_pins(input logic order_n, input logic oe_n);
    @(posedge clk_i);
    order_n_o <= order_n;
    oe_n_o <= oe_n;
  endtask
endmodule // sbs_ctrl_model
`default_nettype wire

/* sbs_lane_wr.sv */
// Lane write decoder: which data lanes a registered write touches.
// Assumes all inputs are already registered on the block clock.
`timescale 1ns/100ps
`default_nettype none
`include "sbs_map.svh"
module sbs_lane_wr
  import sbs_pkg::*;
#(
  parameter int unsigned NUM_LANES = `SBS_LANES
)
(
  input  wire logic [3:0] lane_wen_n_i, // lane write enables, low writes
  input  wire logic       gate_n_i,     // byte-write gate, low active
  input  wire logic       all_n_i,      // all-lanes write, low active
  output logic      [3:0] mask_o        // lanes to write this cycle
);
  genvar g;
  generate
    for (g = 0; g < `SBS_LANES; g++) begin : g_lane
      if (g < NUM_LANES) begin : g_on
        // all-lanes write overrides the gate; lane bit only with gate low
        assign mask_o[g] = !all_n_i || (!gate_n_i && !lane_wen_n_i[g]);
      end else begin : g_off
        assign mask_o[g] = 1'b0;
      end
    end
  endgenerate
endmodule // sbs_lane_wr
`default_nettype wire

/* sbs_map.svh */
// Constants of the synchronous burst SRAM byte-write port: widths, depth,
// pin idle levels and counts. Included by the lane write decoder and the port module.
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH

`define SBS_ADDR_W    17
`define SBS_HI_W      15
`define SBS_LOW_W     2
`define SBS_DEPTH     131072
`define SBS_LANES     4
`define SBS_LANES_X18 2
`define SBS_LANE_W    9
`define SBS_DATA_W    36
`define SBS_PIN_IDLE  1'h1
`define SBS_PIN_ACT   1'h0
`define SBS_LOW_ZERO  2'h0
`define SBS_LOW_ONE   2'h1
`define SBS_LOW_TWO   2'h2
`define SBS_LOW_TOP   2'h3
`define SBS_WEN_IDLE  4'hF
`define SBS_MASK_NONE 4'h0

`endif

/* sbs_pkg.sv */
// Types shared by the burst SRAM port files.
// Assumes sbs_map.svh supplies the widths.
`default_nettype none
package sbs_pkg;

  // operation held for the current cycle of an access
  typedef enum logic [1:0] {
    SBS_ST_DESEL = 2'b00,
    SBS_ST_READ  = 2'b01,
    SBS_ST_WRITE = 2'b10
  } sbs_op_t;

endpackage
`default_nettype wire

/* sbs_sram_port.sv */
// Synchronous pipelined burst SRAM, 128K words of four 9-bit lanes.
// Assumes a synchronous controller on clk_i; output enable and burst
// order are slow pins and are synchronised before use.
`timescale 1ns/100ps
`default_nettype none
`include "sbs_map.svh"
module sbs_sram_port
  import sbs_pkg::*;
#(
  parameter int unsigned NUM_LANES = `SBS_LANES
)
(
  input  wire logic                  clk_i,               // block clock
  input  wire logic                  sys_rst_i,           // sync reset
  input  wire logic [`SBS_HI_W-1:0]  addr_i,              // upper address
  input  wire logic                  burst_addr_bit0_i,   // address bit 0
  input  wire logic                  burst_addr_bit1_i,   // address bit 1
  input  wire logic                  lane0_write_en_n_i,  // lane 0 write
  input  wire logic                  lane1_write_en_n_i,  // lane 1 write
  input  wire logic                  lane2_write_en_n_i,  // lane 2 write
  input  wire logic                  lane3_write_en_n_i,  // lane 3 write
  input  wire logic                  byte_write_gate_n_i, // lane gate
  input  wire logic                  all_lanes_write_n_i, // write all
  input  wire logic                  chip_en_n_i,         // primary select
  input  wire logic                  extra_select_n_i,    // low select
  input  wire logic                  extra_select_i,      // high select
  input  wire logic                  proc_addr_strobe_n_i, // proc start
  input  wire logic                  ctrl_addr_strobe_n_i, // ctrl start
  input  wire logic                  burst_advance_n_i,   // step burst
  input  wire logic                  burst_order_n_i,     // low: linear
  input  wire logic                  out_en_n_i,          // output enable
  input  wire logic [`SBS_LANE_W-1:0] data_lane0_i,       // lane 0 in
  input  wire logic [`SBS_LANE_W-1:0] data_lane1_i,       // lane 1 in
  input  wire logic [`SBS_LANE_W-1:0] data_lane2_i,       // lane 2 in
  input  wire logic [`SBS_LANE_W-1:0] data_lane3_i,       // lane 3 in
  output logic      [`SBS_LANE_W-1:0] data_lane0_o,       // lane 0 out
  output logic      [`SBS_LANE_W-1:0] data_lane1_o,       // lane 1 out
  output logic      [`SBS_LANE_W-1:0] data_lane2_o,       // lane 2 out
  output logic      [`SBS_LANE_W-1:0] data_lane3_o,       // lane 3 out
  output logic                  data_lane0_oe_n_o,        // lane 0 drive
  output logic                  data_lane1_oe_n_o,        // lane 1 drive
  output logic                  data_lane2_oe_n_o,        // lane 2 drive
  output logic                  data_lane3_oe_n_o         // lane 3 drive
);

  logic [`SBS_HI_W-1:0]   addr_hi_r;
  logic [1:0]             low_r;
  logic [3:0]             lane_wen_n_r;
  logic                   gate_n_r;
  logic                   all_n_r;
  logic                   chip_en_n_r;
  logic                   extra_sel_n_r;
  logic                   extra_sel_r;
  logic                   pstb_n_r;
  logic                   cstb_n_r;
  logic                   advance_n_r;
  logic [`SBS_DATA_W-1:0] wdata_r;
  logic                   oe_s1_r;
  logic                   oe_s2_r;
  logic                   order_s1_r;
  logic                   order_s2_r;
  sbs_op_t                op_r;
  sbs_op_t                op_nxt;
  logic [`SBS_HI_W-1:0]   hi_r;
  logic [1:0]             start_r;
  logic [1:0]             cnt_r;
  logic [`SBS_HI_W-1:0]   hi_sel;
  logic [1:0]             start_sel;
  logic [1:0]             cnt_sel;
  logic [1:0]             low_sel;
  logic [`SBS_ADDR_W-1:0] mem_addr;
  logic [3:0]             lane_mask;
  logic                   sel_ok;
  logic                   p_start;
  logic                   c_start;
  logic                   new_acc;
  logic                   any_wr;
  logic                   lane_hiz;
  logic                   linear;
  logic [`SBS_DATA_W-1:0] q_r;
  logic                   drive_n_r;
  logic [`SBS_DATA_W-1:0] mem [0:`SBS_DEPTH-1];

  // every synchronous pin captured on the same edge
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      addr_hi_r     <= '0;
      low_r         <= `SBS_LOW_ZERO;
      lane_wen_n_r  <= `SBS_WEN_IDLE;
      gate_n_r      <= `SBS_PIN_IDLE;
      all_n_r       <= `SBS_PIN_IDLE;
      chip_en_n_r   <= `SBS_PIN_IDLE;
      extra_sel_n_r <= `SBS_PIN_IDLE;
      extra_sel_r   <= `SBS_PIN_ACT;
      pstb_n_r      <= `SBS_PIN_IDLE;
      cstb_n_r      <= `SBS_PIN_IDLE;
      advance_n_r   <= `SBS_PIN_IDLE;
      wdata_r       <= '0;
    end else begin
      addr_hi_r     <= addr_i;
      low_r         <= {burst_addr_bit1_i, burst_addr_bit0_i};
      lane_wen_n_r  <= {lane3_write_en_n_i, lane2_write_en_n_i,
                        lane1_write_en_n_i, lane0_write_en_n_i};
      gate_n_r      <= byte_write_gate_n_i;
      all_n_r       <= all_lanes_write_n_i;
      chip_en_n_r   <= chip_en_n_i;
      extra_sel_n_r <= extra_select_n_i;
      extra_sel_r   <= extra_select_i;
      pstb_n_r      <= proc_addr_strobe_n_i;
      cstb_n_r      <= ctrl_addr_strobe_n_i;
      advance_n_r   <= burst_advance_n_i;
      wdata_r       <= {data_lane3_i, data_lane2_i,
                        data_lane1_i, data_lane0_i};
    end
  end

  // asynchronous pins: two flops; output enable therefore lags two cycles
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      oe_s1_r    <= `SBS_PIN_IDLE;
      oe_s2_r    <= `SBS_PIN_IDLE;
      order_s1_r <= `SBS_PIN_IDLE;
      order_s2_r <= `SBS_PIN_IDLE;
    end else begin
      oe_s1_r    <= out_en_n_i;
      oe_s2_r    <= oe_s1_r;
      order_s1_r <= burst_order_n_i;
      order_s2_r <= order_s1_r;
    end
  end

  assign linear = !order_s2_r;

  sbs_lane_wr #(
    .NUM_LANES (NUM_LANES)
  ) u_lane_wr (
    .lane_wen_n_i (lane_wen_n_r),
    .gate_n_i     (gate_n_r),
    .all_n_i      (all_n_r),
    .mask_o       (lane_mask)
  );

  sbs_burst_seq u_burst_seq (
    .start_i  (start_sel),
    .step_i   (cnt_sel),
    .linear_i (linear),
    .low_o    (low_sel)
  );

  // decode of the registered controls
  always_comb begin
    sel_ok   = !chip_en_n_r && !extra_sel_n_r && extra_sel_r;
    p_start  = !pstb_n_r && !chip_en_n_r;
    c_start  = !p_start && !cstb_n_r;
    new_acc  = p_start || c_start;
    any_wr   = |lane_mask;
    lane_hiz = !gate_n_r && (lane_wen_n_r != `SBS_WEN_IDLE);
    if (p_start) begin
      op_nxt = sel_ok ? SBS_ST_READ : SBS_ST_DESEL;
    end else if (c_start) begin
      if (!sel_ok) begin
        op_nxt = SBS_ST_DESEL;
      end else begin
        op_nxt = any_wr ? SBS_ST_WRITE : SBS_ST_READ;
      end
    end else if (op_r == SBS_ST_DESEL) begin
      op_nxt = SBS_ST_DESEL;
    end else begin
      op_nxt = any_wr ? SBS_ST_WRITE : SBS_ST_READ;
    end
  end

  // low bits from the counter once the access is under way
  always_comb begin
    hi_sel    = new_acc ? addr_hi_r : hi_r;
    start_sel = new_acc ? low_r : start_r;
    if (new_acc) begin
      cnt_sel = `SBS_LOW_ZERO;
    end else if (!advance_n_r && op_r != SBS_ST_DESEL) begin
      cnt_sel = 2'(cnt_r + `SBS_LOW_ONE);
    end else begin
      cnt_sel = cnt_r;
    end
    mem_addr = {hi_sel, low_sel};
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      op_r    <= SBS_ST_DESEL;
      hi_r    <= '0;
      start_r <= `SBS_LOW_ZERO;
      cnt_r   <= `SBS_LOW_ZERO;
    end else begin
      op_r    <= op_nxt;
      hi_r    <= hi_sel;
      start_r <= start_sel;
      cnt_r   <= cnt_sel;
    end
  end

  // self-timed write: only the lanes in the mask change
  always_ff @(posedge clk_i) begin
    if (op_nxt == SBS_ST_WRITE) begin
      for (int l = 0; l < `SBS_LANES; l++) begin
        if (lane_mask[l]) begin
          mem[mem_addr][l*`SBS_LANE_W +: `SBS_LANE_W] <=
            wdata_r[l*`SBS_LANE_W +: `SBS_LANE_W];
        end
      end
    end
  end

  // pipelined read data; pins released on writes and deselects
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q_r       <= '0;
      drive_n_r <= `SBS_PIN_IDLE;
    end else begin
      if (op_nxt == SBS_ST_READ) begin
        q_r <= mem[mem_addr];
      end
      drive_n_r <= (op_nxt != SBS_ST_READ) || oe_s2_r || lane_hiz;
    end
  end

  assign data_lane0_o      = q_r[0*`SBS_LANE_W +: `SBS_LANE_W];
  assign data_lane1_o      = q_r[1*`SBS_LANE_W +: `SBS_LANE_W];
  assign data_lane2_o      = q_r[2*`SBS_LANE_W +: `SBS_LANE_W];
  assign data_lane3_o      = q_r[3*`SBS_LANE_W +: `SBS_LANE_W];
  assign data_lane0_oe_n_o = drive_n_r;
  assign data_lane1_oe_n_o = drive_n_r;
  assign data_lane2_oe_n_o = drive_n_r;
  assign data_lane3_oe_n_o = drive_n_r;

  property p_capture_addr;
    @(posedge clk_i) disable iff (sys_rst_i)
      new_acc |=> hi_r == $past(addr_hi_r) && start_r == $past(low_r);
  endproperty
  a_capture_addr: assert property (p_capture_addr)
    else $error("new access did not load the pin address");

  property p_internal_low;
    @(posedge clk_i) disable iff (sys_rst_i)
      !new_acc |-> hi_sel == hi_r && start_sel == start_r;
  endproperty
  a_internal_low: assert property (p_internal_low)
    else $error("burst took its address from the pins");

  property p_lane_map;
    @(posedge clk_i) disable iff (sys_rst_i)
      (NUM_LANES == `SBS_LANES && all_n_r && !gate_n_r)
        |-> lane_mask == ~lane_wen_n_r;
  endproperty
  a_lane_map: assert property (p_lane_map)
    else $error("lane write mask does not follow lane enables");

  property p_hiz_on_write;
    @(posedge clk_i) disable iff (sys_rst_i)
      lane_hiz |=> drive_n_r;
  endproperty
  a_hiz_on_write: assert property (p_hiz_on_write)
    else $error("data pins driven during a gated lane write");

  property p_gate_ignored;
    @(posedge clk_i) disable iff (sys_rst_i)
      (all_n_r && gate_n_r) |-> lane_mask == `SBS_MASK_NONE;
  endproperty
  a_gate_ignored: assert property (p_gate_ignored)
    else $error("lane enables acted with the gate high");

  property p_all_lanes;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!all_n_r && NUM_LANES == `SBS_LANES && c_start && sel_ok)
        |-> lane_mask == `SBS_WEN_IDLE ##1 op_r == SBS_ST_WRITE;
  endproperty
  a_all_lanes: assert property (p_all_lanes)
    else $error("all-lanes write did not write every lane");

  property p_strobe_gated;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!pstb_n_r && chip_en_n_r && cstb_n_r && op_r == SBS_ST_DESEL)
        |=> op_r == SBS_ST_DESEL;
  endproperty
  a_strobe_gated: assert property (p_strobe_gated)
    else $error("processor strobe acted without chip enable");

  property p_extra_sel;
    @(posedge clk_i) disable iff (sys_rst_i)
      (new_acc && (extra_sel_n_r || !extra_sel_r))
        |=> op_r == SBS_ST_DESEL && drive_n_r;
  endproperty
  a_extra_sel: assert property (p_extra_sel)
    else $error("device selected with extra select inactive");

  property p_x18_lanes;
    @(posedge clk_i) disable iff (sys_rst_i)
      NUM_LANES == `SBS_LANES_X18 |-> lane_mask[3:2] == 2'h0;
  endproperty
  a_x18_lanes: assert property (p_x18_lanes)
    else $error("absent lane written in the narrow organisation");

  property p_advance_step;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!new_acc && op_r != SBS_ST_DESEL && !advance_n_r)
        |=> cnt_r == 2'($past(cnt_r) + `SBS_LOW_ONE);
  endproperty
  a_advance_step: assert property (p_advance_step)
    else $error("burst counter did not step on advance");

  property p_wait_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!new_acc && advance_n_r) |=> $stable(cnt_r) && $stable(start_r);
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("wait cycle moved the burst address");

  property p_order;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!new_acc && op_r != SBS_ST_DESEL && !advance_n_r
       && start_r == `SBS_LOW_ONE && cnt_r == `SBS_LOW_ZERO)
        |-> low_sel == (linear ? `SBS_LOW_TWO : `SBS_LOW_ZERO);
  endproperty
  a_order: assert property (p_order)
    else $error("second burst address in the wrong order");

  property p_proc_read;
    @(posedge clk_i) disable iff (sys_rst_i)
      (p_start && sel_ok) |=> op_r == SBS_ST_READ && cnt_r == `SBS_LOW_ZERO;
  endproperty
  a_proc_read: assert property (p_proc_read)
    else $error("processor strobe did not begin a read");

  property p_ctrl_start;
    @(posedge clk_i) disable iff (sys_rst_i)
      (c_start && sel_ok) |=>
        op_r == ($past(any_wr) ? SBS_ST_WRITE : SBS_ST_READ);
  endproperty
  a_ctrl_start: assert property (p_ctrl_start)
    else $error("controller strobe began the wrong operation");
endmodule // sbs_sram_port
`default_nettype wire

/* sync_burst_sram_byte_write_port_test.sv */
// Self-checking bench for the burst SRAM port, controller model as driver.
// Assumes each step() is one bus cycle; results show two edges later.
`timescale 1ns/100ps
`default_nettype none
module sync_burst_sram_byte_write_port_test;
  localparam logic [3:0] S_CTRL = 4'hA;
  localparam logic [3:0] S_PROC = 4'h6;
  localparam logic [3:0] S_CONT = 4'hC;
  localparam logic [3:0] S_SUSP = 4'hE;
  localparam logic [3:0] S_DES  = 4'hB;
  localparam logic [7:0] RD     = 8'hBF;
  localparam logic [7:0] WALL   = 8'hAF;
  // {sel, sel_n, gate_n, all_n, lane enables} beside the lanes written
  localparam logic [0:8][11:0] ROWS = {12'hAFF, 12'h80F, 12'h9E1, 12'h9D2,
    12'h9B4, 12'h978, 12'hB00, 12'h9F0, 12'h9C3};

  logic        clk = 1'b0;
  logic        sys_rst;
  logic [16:0] addr;
  logic        pstb_n, cstb_n, adv_n, cen_n, sel_n, sel, gate_n, all_n;
  logic        order_n, oe_n;
  logic [3:0]  wen_n;
  logic [35:0] bus, dq;
  logic [3:0]  doe_n;
  logic [35:0] shadow [0:1023];
  logic [1:0]  m1 = 2'h0;
  logic [1:0]  m2 = 2'h0;
  logic [35:0] d1, d2;
  int          err_count = 0;
  int          samples_checked = 0;

  always #2.5 clk = ~clk;

  sbs_ctrl_model i_sbs_ctrl_model (.clk_i(clk), .dev_q_i(dq),
    .dev_oe_n_i(doe_n), .addr_o(addr), .pstb_n_o(pstb_n), .cstb_n_o(cstb_n),
    .adv_n_o(adv_n), .cen_n_o(cen_n), .sel_n_o(sel_n), .sel_o(sel),
    .gate_n_o(gate_n), .all_n_o(all_n), .wen_n_o(wen_n),
    .order_n_o(order_n), .oe_n_o(oe_n), .bus_o(bus));

  sbs_sram_port i_sbs_sram_port (.clk_i(clk), .sys_rst_i(sys_rst),
    .addr_i(addr[16:2]), .burst_addr_bit0_i(addr[0]),
    .burst_addr_bit1_i(addr[1]), .lane0_write_en_n_i(wen_n[0]),
    .lane1_write_en_n_i(wen_n[1]), .lane2_write_en_n_i(wen_n[2]),
    .lane3_write_en_n_i(wen_n[3]), .byte_write_gate_n_i(gate_n),
    .all_lanes_write_n_i(all_n), .chip_en_n_i(cen_n),
    .extra_select_n_i(sel_n), .extra_select_i(sel),
    .proc_addr_strobe_n_i(pstb_n), .ctrl_addr_strobe_n_i(cstb_n),
    .burst_advance_n_i(adv_n), .burst_order_n_i(order_n),
    .out_en_n_i(oe_n), .data_lane0_i(bus[8:0]), .data_lane1_i(bus[17:9]),
    .data_lane2_i(bus[26:18]), .data_lane3_i(bus[35:27]),
    .data_lane0_o(dq[8:0]), .data_lane1_o(dq[17:9]),
    .data_lane2_o(dq[26:18]), .data_lane3_o(dq[35:27]),
    .data_lane0_oe_n_o(doe_n[0]), .data_lane1_oe_n_o(doe_n[1]),
    .data_lane2_oe_n_o(doe_n[2]), .data_lane3_oe_n_o(doe_n[3]));

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // mode 0 none, 1 lanes released, 2 read of ea, 3 write of ea by mask
  task automatic step(input logic [3:0] strb, input logic [16:0] a,
                      input logic [7:0] ctl, input logic [35:0] d,
                      input logic [1:0] mode, input logic [16:0] ea,
                      input logic [3:0] mask);
    logic [35:0] ed;
    ed = 36'h000000000;
    if (mode == 2'h3) begin
      for (int g = 0; g < 4; g++)
        if (mask[g]) shadow[ea[9:0]][g*9+:9] = d[g*9+:9];
    end
    if (mode == 2'h2) ed = shadow[ea[9:0]];
    i_sbs_ctrl_model.cyc(strb, a, ctl, d);
    #1;
    if (m2 == 2'h2) chk({doe_n, dq}, {4'h0, d2});
    else if (m2 != 2'h0) chk({36'h0, doe_n}, {36'h0, 4'hF});
    m2 = m1;
    d2 = d1;
    m1 = mode;
    d1 = ed;
  endtask

  task automatic idle(input int n);
    repeat (n) step(S_DES, 17'h1FFFF, RD, 36'h0, 2'h1, 17'h0, 4'h0);
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    // whole sequence needs well under 400 cycles
    repeat (3000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    logic [16:0] a;
    logic [1:0]  lo;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({doe_n, dq}, {4'hF, 36'h0}); // released, read data cleared
    idle(2);
    for (int i = 0; i < 9; i++) begin
      a = 17'h00100 + 17'(i * 4);
      step(S_CTRL, a, WALL, 36'h0AAAAAAAA, 2'h3, a, 4'hF);
      step(S_CTRL, a, ROWS[i][11:4], 36'h955555555,
           (ROWS[i][3:0] == 4'h0) ? 2'h2 : 2'h3, a, ROWS[i][3:0]);
      step(S_CTRL, a, RD, 36'h0, 2'h2, a, 4'h0);
      // read data stands two cycles on; keep it off the next write data
      idle(2);
    end
    a = 17'h00200;
    step(S_CTRL, a, WALL, 36'h123456789, 2'h3, a, 4'hF);
    step(S_CTRL, a, 8'h3F, 36'h0, 2'h1, a, 4'h0);
    step(S_CTRL, a, 8'hFF, 36'h0, 2'h1, a, 4'h0);
    step(S_CTRL, a, 8'h2F, 36'hFFFFFFFFF, 2'h1, a, 4'h0);
    step(4'h7, a, RD, 36'h0, 2'h1, a, 4'h0);
    // both strobes with write controls low: the processor start reads
    step(4'h2, a, WALL, 36'h0F0F0F0F0, 2'h2, a, 4'h0);
    step(S_CTRL, a, RD, 36'h0, 2'h2, a, 4'h0);
    step(S_PROC, a, 8'h9E, 36'h0, 2'h1, a, 4'h0);
    idle(2);
    i_sbs_ctrl_model.set_pins(1'b0, 1'b1);
    idle(3);
    step(S_CTRL, a, RD, 36'h0, 2'h1, a, 4'h0);
    for (int o = 0; o < 2; o++) begin
      idle(2);
      i_sbs_ctrl_model.set_pins(o[0], 1'b0);
      idle(3);
      // from a start of 0 both orders visit 0,1,2,3
      for (int j = 0; j < 4; j++)
        step((j == 0) ? S_CTRL : S_CONT, (j == 0) ? 17'h00300 : 17'h1FFFF,
             WALL, 36'h111111111 * 36'(j + 1) + 36'(o), 2'h3,
             17'h00300 + 17'(j), 4'hF);
      step(S_PROC, 17'h00301, RD, 36'h0, 2'h2, 17'h00301, 4'h0);
      for (int s = 1; s < 5; s++) begin
        lo = o[0] ? (2'h1 ^ 2'(s)) : (2'h1 + 2'(s));
        step(S_CONT, 17'h1FFFF ^ 17'(s), RD, 36'h0, 2'h2,
             {15'h00C0, lo}, 4'h0);
        if (s == 2)
          step(S_SUSP, 17'h0, RD, 36'h0, 2'h2, {15'h00C0, lo}, 4'h0);
      end
    end
    idle(3);
    tally_and_finish();
  end
endmodule // sync_burst_sram_byte_write_port_test
`default_nettype wire
